/* File: dram_on_die_termination_ctrl.sv */
// on-die termination control with a classic wishbone register slave
`include "dram_odt_regs.svh"
module dram_on_die_termination_ctrl #(
    parameter int HIST_DEPTH = 96
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // termination pin and device events
    input wire logic odt_pin_i,
    input wire logic cmd_write_i,
    input wire logic cmd_read_i,
    input wire logic cmd_chop4_i,
    input wire logic self_refresh_i,
    input wire logic zq_cal_i,
    input wire logic dll_locked_i,
    // termination outputs
    output term_pkg::term_out_t term_o,
    output logic [7:0] term_ohms_o,
    output term_pkg::term_lanes_t lanes_o,
    output logic odt_rx_en_o
);
    import term_pkg::*;

    if (HIST_DEPTH < 88) begin : g_depth_check
        $error("HIST_DEPTH must cover the longest latency plus window");
    end

    //------------------------------------------------------------------
    // helper functions
    //------------------------------------------------------------------
    function automatic logic [7:0] code_to_ohms(input logic [2:0] code);
        logic [7:0] r;
        r = 8'h00;
        case (code)
            3'h1: r = 8'hF0;
            3'h2: r = 8'h78;
            3'h3: r = 8'h50;
            3'h4: r = 8'h3C;
            3'h5: r = 8'h30;
            3'h6: r = 8'h28;
            3'h7: r = 8'h22;
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    function automatic logic [7:0] wr_len(input logic chop, input logic pre2,
                                          input logic crc);
        logic [7:0] r;
        r = `WR8_1T;
        case ({chop, pre2, crc})
            3'b100: r = `WR4_1T;
            3'b101: r = `WR4_1T_CRC;
            3'b110: r = `WR4_2T;
            3'b111: r = `WR4_2T_CRC;
            3'b000: r = `WR8_1T;
            3'b001: r = `WR8_1T_CRC;
            3'b010: r = `WR8_2T;
            default: r = `WR8_2T_CRC;
        endcase
        return r;
    endfunction

    //------------------------------------------------------------------
    // register file
    //------------------------------------------------------------------
    logic [31:0] mode_r;
    logic [31:0] cfg_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic [31:0] stat_w;
    logic req;
    term_out_t term_r;
    term_out_t term_nxt;
    logic pin_s_r;
    logic odt_en;

    assign req = wb_cyc_i && wb_stb_i;
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req && !ack_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_r <= `MODE_RST;
            cfg_r <= `CFG_RST;
        end else if (req && ack_r && wb_we_i) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b] && wb_adr_i == `TERM_MODE_ADR) begin
                    mode_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
                end
                if (wb_sel_i[b] && wb_adr_i == `TERM_CFG_ADR) begin
                    cfg_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
                end
            end
        end
    end

    assign stat_w = {23'h00_0000, pin_s_r, dll_locked_i, odt_rx_en_o,
                     odt_en, term_r.code, term_r.state};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (req && !ack_r) begin
            if (wb_adr_i == `TERM_MODE_ADR) begin
                dat_r <= {23'h00_0000, mode_r[8:0]};
            end else if (wb_adr_i == `TERM_CFG_ADR) begin
                dat_r <= {3'h0, cfg_r[28:0]};
            end else if (wb_adr_i == `TERM_STAT_ADR) begin
                dat_r <= stat_w;
            end else begin
                dat_r <= 32'h0000_0000;
            end
        end
    end

    //------------------------------------------------------------------
    // field decode
    //------------------------------------------------------------------
    logic [2:0] nom_code;
    logic [2:0] wr_code;
    logic [2:0] park_code;
    logic pre2;
    logic crc;
    logic chop_fixed;
    logic nom_en;
    logic wr_en;
    logic park_en;
    logic [6:0] wl_sum;
    logic [6:0] lat;

    assign nom_code = mode_r[`NOM_LSB +: 3];
    assign wr_code = mode_r[`WR_LSB +: 3];
    assign park_code = mode_r[`PARK_LSB +: 3];
    assign pre2 = cfg_r[`PRE2_BIT];
    assign crc = cfg_r[`CRC_BIT];
    assign chop_fixed = cfg_r[`BC4FIX_BIT];
    // zero code is off; write field only has three resistances
    assign nom_en = nom_code != 3'h0;
    assign park_en = park_code != 3'h0;
    assign wr_en = wr_code != 3'h0 && wr_code <= 3'h3;
    assign odt_en = nom_en || wr_en || park_en;

    // write plus additive plus parity latency, less the preamble term
    assign wl_sum = 7'(cfg_r[`WLAT_LSB +: 5]) + 7'(cfg_r[`ADDLAT_LSB +: 5])
                  + 7'(cfg_r[`PARLAT_LSB +: 4]);
    always_comb begin
        lat = 7'h01;
        if (pre2 && wl_sum > `PRE2_SUB) begin
            lat = wl_sum - `PRE2_SUB;
        end else if (!pre2 && wl_sum > `PRE1_SUB) begin
            lat = wl_sum - `PRE1_SUB;
        end
    end

    //------------------------------------------------------------------
    // pin synchroniser and event history
    //------------------------------------------------------------------
    logic pin_meta_r;
    logic [HIST_DEPTH-1:0] pin_hist_r;
    logic [HIST_DEPTH-1:0] wr_hist_r;
    logic [HIST_DEPTH-1:0] chop_hist_r;
    logic [HIST_DEPTH-1:0] rd_hist_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta_r <= 1'b0;
            pin_s_r <= 1'b0;
        end else begin
            pin_meta_r <= odt_pin_i;
            pin_s_r <= pin_meta_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_hist_r <= '0;
        end else begin
            pin_hist_r <= {pin_hist_r[HIST_DEPTH-2:0], pin_s_r};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_hist_r <= '0;
            chop_hist_r <= '0;
            rd_hist_r <= '0;
        end else begin
            wr_hist_r <= {wr_hist_r[HIST_DEPTH-2:0], cmd_write_i};
            chop_hist_r <= {chop_hist_r[HIST_DEPTH-2:0], cmd_chop4_i};
            rd_hist_r <= {rd_hist_r[HIST_DEPTH-2:0], cmd_read_i};
        end
    end

    //------------------------------------------------------------------
    // timing windows
    //------------------------------------------------------------------
    logic sync_mode;
    logic pin_seen;
    logic wr_act;
    logic rd_act;
    logic [7:0] lat8;
    logic [7:0] park_add;

    assign sync_mode = dll_locked_i;
    assign lat8 = {1'b0, lat};

    // locked: pin acts a full latency late; unlocked: no added delay
    assign pin_seen = sync_mode ? pin_hist_r[lat - 7'h01] : pin_s_r;

    always_comb begin
        park_add = pre2 ? `PARK_OTF_2T : `PARK_OTF_1T;
        if (chop_fixed) begin
            park_add = pre2 ? `PARK_BC4_2T : `PARK_BC4_1T;
        end
    end

    always_comb begin
        logic [7:0] k;
        logic [7:0] len;
        k = 8'h00;
        len = 8'h00;
        wr_act = 1'b0;
        rd_act = 1'b0;
        for (int i = 0; i < HIST_DEPTH; i++) begin
            k = 8'(i + 1);
            len = wr_len(chop_hist_r[i] || chop_fixed, pre2, crc);
            // dynamic write termination needs the locked loop
            if (sync_mode && wr_hist_r[i] && k >= lat8
                && k < lat8 + len) begin
                wr_act = 1'b1;
            end
            if (rd_hist_r[i] && k >= lat8 && k < lat8 + park_add) begin
                rd_act = 1'b1;
            end
        end
    end

    //------------------------------------------------------------------
    // termination selection
    //------------------------------------------------------------------
    logic dis;
    logic nom_on;

    assign dis = self_refresh_i || zq_cal_i || rd_act;
    assign nom_on = nom_en && !self_refresh_i && pin_seen;

    always_comb begin
        term_nxt = '{state: RTT_OFF, code: 3'h0};
        if (dis || !odt_en) begin
            term_nxt = '{state: RTT_OFF, code: 3'h0};
        end else if (wr_act && wr_en) begin
            term_nxt = '{state: RTT_WR, code: wr_code};
        end else if (nom_on) begin
            term_nxt = '{state: RTT_NOMINAL, code: nom_code};
        end else if (park_en) begin
            term_nxt = '{state: RTT_PARK, code: park_code};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            term_r <= '{state: RTT_OFF, code: 3'h0};
            term_ohms_o <= 8'h00;
        end else begin
            term_r <= term_nxt;
            term_ohms_o <= code_to_ohms(term_nxt.code);
        end
    end

    assign term_o = term_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lanes_o <= '0;
        end else if (term_nxt.state == RTT_OFF) begin
            lanes_o <= '0;
        end else begin
            lanes_o.dq <= 1'b1;
            lanes_o.dqs[0] <= 1'b1;
            lanes_o.dm[0] <= 1'b1;
            lanes_o.dqs[1] <= cfg_r[`X16_BIT];
            lanes_o.dm[1] <= cfg_r[`X16_BIT];
            lanes_o.term_strobe <= !cfg_r[`X16_BIT] && cfg_r[`TERM_STROBE_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            odt_rx_en_o <= 1'b0;
        end else begin
            odt_rx_en_o <= nom_en;
        end
    end

    //------------------------------------------------------------------
    // assertions
    //------------------------------------------------------------------
    AST_SR_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        self_refresh_i |=> term_r.state == RTT_OFF && term_ohms_o == 8'h00)
        else $error("termination active in self refresh");

    AST_CAL_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        zq_cal_i |=> term_r.state == RTT_OFF)
        else $error("termination active during calibration");

    AST_READ_HIZ: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_act |=> term_r.state == RTT_OFF && lanes_o == '0)
        else $error("termination active in read window");

    AST_WR_PRIO: assert property (@(posedge clk_i) disable iff (rst_i)
        !dis && wr_act && wr_en |=> term_r.state == RTT_WR
            && term_r.code == $past(wr_code))
        else $error("write termination not applied");

    AST_NOM_ON: assert property (@(posedge clk_i) disable iff (rst_i)
        !dis && !(wr_act && wr_en) && nom_on
            |=> term_r.state == RTT_NOMINAL && term_r.code == $past(nom_code))
        else $error("nominal termination not applied");

    AST_PARK: assert property (@(posedge clk_i) disable iff (rst_i)
        !dis && !(wr_act && wr_en) && !nom_on && park_en
            |=> term_r.state == RTT_PARK)
        else $error("parked termination not applied");

    AST_PIN_IGNORED: assert property (@(posedge clk_i) disable iff (rst_i)
        (!nom_en || self_refresh_i) |=> term_r.state != RTT_NOMINAL)
        else $error("pin acted while it should be ignored");

    AST_RX_PWR: assert property (@(posedge clk_i) disable iff (rst_i)
        !nom_en ##1 !nom_en |-> !odt_rx_en_o)
        else $error("pin receiver powered with nominal off");

    AST_WR_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
        term_r.state == RTT_WR |-> term_r.code inside {3'h1, 3'h2, 3'h3}
            && term_ohms_o >= 8'h50)
        else $error("write termination code out of range");

    AST_LANES: assert property (@(posedge clk_i) disable iff (rst_i)
        term_nxt.state != RTT_OFF && cfg_r[`X16_BIT]
            |=> lanes_o.dm == 2'b11 && lanes_o.dqs == 2'b11 && !lanes_o.term_strobe)
        else $error("x16 lanes not all terminated");

    AST_DIRECT_LAT: assert property (@(posedge clk_i) disable iff (rst_i)
        sync_mode && $stable(lat) && nom_en && !self_refresh_i
            |-> nom_on == pin_hist_r[lat - 7'h01])
        else $error("nominal switch not at direct latency");
endmodule

/* File: dram_odt_regs.svh */
// register map, field positions, reset values and latency constants
//------------------------------------------------------------------
// Functional notes
//------------------------------------------------------------------
// Functional notes
// - priority: disable, then write, then nominal, then parked termination
// - termination enabled when the nominal or parked field is non-zero or the write field is 1 to 3
// - pin ignored when nominal field is zero or in self refresh
// - no termination at all during self refresh
// - written rank applies write termination whatever the pin level
// - nominal termination applied while the pin is sampled high
// - pin low or nominal off: parked if enabled, else high impedance
// - after read, high impedance for the read window regardless of settings
// - pin receiver powered down when nominal field is zero
// - nominal and parked: off, 240, 120, 80, 60, 48, 40, 34 ohms
// - write field: off, 240, 120, 80 ohms only
// - x16 terminates all data, both masks, both strobes; x8 adds strobe pair
// - synchronous timing whenever the delay-locked loop is locked
// - nominal switches a fixed latency after the pin is sampled high or low
// - direct latencies are write+additive+parity latency minus 2 or 3
// - read turn-off latency uses the same sum
// - parked returns at read turn-off plus 6 or plus 7 on the fly
// - fixed chop-4 two-cycle preamble: parked returns at read turn-off plus 5
// - no termination while driving read data, only after postamble
// - termination disabled automatically during impedance calibration
// - write termination from write latency minus 2 or 3 for a burst dependent span
// - with the loop unlocked the pin is not delayed by additive or parity
`ifndef DRAM_ODT_REGS_SVH
`define DRAM_ODT_REGS_SVH
`define TERM_MODE_ADR 8'h00
`define TERM_CFG_ADR 8'h04
`define TERM_STAT_ADR 8'h08
`define NOM_LSB 0
`define WR_LSB 3
`define PARK_LSB 6
`define WLAT_LSB 0
`define ADDLAT_LSB 8
`define PARLAT_LSB 16
`define PRE2_BIT 24
`define CRC_BIT 25
`define BC4FIX_BIT 26
`define X16_BIT 27
`define TERM_STROBE_BIT 28
`define MODE_RST 32'h0000_0000
`define CFG_RST 32'h0000_0009
`define PRE1_SUB 7'h02
`define PRE2_SUB 7'h03
`define PARK_OTF_1T 8'h06
`define PARK_OTF_2T 8'h07
`define PARK_BC4_1T 8'h04
`define PARK_BC4_2T 8'h05
`define WR4_1T 8'h04
`define WR4_1T_CRC 8'h05
`define WR4_2T 8'h05
`define WR4_2T_CRC 8'h08
`define WR8_1T 8'h06
`define WR8_1T_CRC 8'h07
`define WR8_2T 8'h07
`define WR8_2T_CRC 8'h08
`endif

/* File: term_pkg.sv */
// types shared by the termination control logic
package term_pkg;
    typedef enum logic [1:0] {
        RTT_OFF = 2'b00,
        RTT_WR = 2'b01,
        RTT_NOMINAL = 2'b10,
        RTT_PARK = 2'b11
    } rtt_state_t;
    typedef struct packed {
        rtt_state_t state;
        logic [2:0] code;
    } term_out_t;
    typedef struct packed {
        logic dq;
        logic [1:0] dm;
        logic [1:0] dqs;
        logic term_strobe;
    } term_lanes_t;
endpackage

/* File: odt_ctrl_model.sv */
// controller-side model that drives the termination pin and commands
module odt_ctrl_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // requests from the bench
    input wire logic pin_req_i,
    input wire logic wr_req_i,
    input wire logic rd_req_i,
    input wire logic chop_req_i,
    input wire logic [3:0] hold_i,
    // device side
    output logic odt_pin_o,
    output logic cmd_write_o,
    output logic cmd_read_o,
    output logic cmd_chop_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] hold_r;
    //------------------------------------------------------------------
    // pin held high for the minimum count, restarted by a write
    //------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            odt_pin_o <= 1'b0;
            hold_r <= 4'h0;
        end else begin
            odt_pin_o <= pin_req_i | (hold_r != 4'h0);
            if ((pin_req_i & ~odt_pin_o) | (wr_req_i & odt_pin_o))
                hold_r <= hold_i;
            else if (hold_r != 4'h0)
                hold_r <= hold_r - 4'h1;
        end
    end
    always_ff @(posedge clk_i) begin
        cmd_write_o <= wr_req_i & ~rst_i;
        cmd_read_o <= rd_req_i & ~rst_i;
        cmd_chop_o <= chop_req_i;
    end
endmodule

/* File: dram_on_die_termination_ctrl_tb.sv */
// self-checking bench for the termination control block
module dram_on_die_termination_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import term_pkg::*;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0] wb_adr_i = 0;
    logic [3:0] wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
    logic wb_ack_o, odt_rx_en_o, odt_pin_i, cmd_write_i, cmd_read_i, cmd_chop_i;
    logic self_refresh_i = 0, zq_cal_i = 0, dll_locked_i = 1;
    logic pin_req = 0, wr_req = 0, rd_req = 0, chop_req = 0;
    term_out_t term_o;
    logic [7:0] term_ohms_o;
    term_lanes_t lanes_o;
    logic [31:0] mode = 0, cfg = 32'h0000_0009;
    logic [7:0] ohm_tab [8] = '{8'h00, 8'hF0, 8'h78, 8'h50, 8'h3C, 8'h30, 8'h28, 8'h22};
    bit wr_h [0:32767], rd_h [0:32767], ch_h [0:32767], pin_h [0:32767];
    int err_total = 0, n_tests = 0, cnt = 0, quiet = 100;

    always #12.5 clk_i = ~clk_i;

    dram_on_die_termination_ctrl dram_on_die_termination_ctrl_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .odt_pin_i(odt_pin_i),
        .cmd_write_i(cmd_write_i), .cmd_read_i(cmd_read_i), .cmd_chop4_i(cmd_chop_i),
        .self_refresh_i(self_refresh_i), .zq_cal_i(zq_cal_i), .dll_locked_i(dll_locked_i),
        .term_o(term_o), .term_ohms_o(term_ohms_o), .lanes_o(lanes_o),
        .odt_rx_en_o(odt_rx_en_o));
    odt_ctrl_model odt_ctrl_model_inst (
        .clk_i(clk_i), .rst_i(rst_i), .pin_req_i(pin_req), .wr_req_i(wr_req),
        .rd_req_i(rd_req), .chop_req_i(chop_req), .hold_i(4'h6), .odt_pin_o(odt_pin_i),
        .cmd_write_o(cmd_write_i), .cmd_read_o(cmd_read_i), .cmd_chop_o(cmd_chop_i));

    //------------------------------------------------------------------
    // helpers
    //------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (err_total == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                      input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (we && sel[i] && adr == 8'h00)
                mode[i*8 +: 8] = dat[i*8 +: 8];
            if (we && sel[i] && adr == 8'h04)
                cfg[i*8 +: 8] = dat[i*8 +: 8];
        end
        if (we)
            quiet = 100;
    endtask
    task automatic cmd(input logic w, input logic r, input logic ch);
        wr_req <= w;
        rd_req <= r;
        chop_req <= ch;
        @(posedge clk_i);
    endtask
    function automatic int wlen(input logic ch);
        if (ch)
            return cfg[24] ? (cfg[25] ? 8 : 5) : (cfg[25] ? 5 : 4);
        return cfg[24] ? (cfg[25] ? 8 : 7) : (cfg[25] ? 7 : 6);
    endfunction
    function automatic int plen();
        if (cfg[26])
            return cfg[24] ? 5 : 4;
        return cfg[24] ? 7 : 6;
    endfunction

    //------------------------------------------------------------------
    // reference model, compared every settled cycle
    //------------------------------------------------------------------
    always @(posedge clk_i) begin
        cnt <= cnt + 1;
        if (cnt > 20000) begin
            err_total++;
            complete_run();
        end
    end
    always @(negedge clk_i) begin
        int L, P;
        logic in_w, in_r, on, pin_d;
        logic [2:0] c;
        rtt_state_t st;
        if (!rst_i) begin
            wr_h[cnt] = cmd_write_i;
            rd_h[cnt] = cmd_read_i;
            ch_h[cnt] = cmd_chop_i | cfg[26];
            pin_h[cnt] = odt_pin_i;
            L = int'(cfg[4:0]) + int'(cfg[12:8]) + int'(cfg[19:16]) - (cfg[24] ? 3 : 2);
            if (L < 1)
                L = 1;
            // pin reaches the output after two sync stages, the latency and the output flop
            P = (dll_locked_i ? L : 0) + 3;
            pin_d = cnt > P && pin_h[cnt - P];
            in_w = 0;
            in_r = 0;
            for (int d = 1; d <= 8; d++) begin
                if (cnt > L + d && wr_h[cnt - L - d] && d <= wlen(ch_h[cnt - L - d]))
                    in_w = 1;
                if (cnt > L + d && rd_h[cnt - L - d] && d <= plen())
                    in_r = 1;
            end
            in_w = in_w & dll_locked_i & (mode[5:3] != 3'h0) & ~mode[5];
            c = 3'h0;
            if (self_refresh_i | zq_cal_i | in_r) begin
                st = RTT_OFF;
            end else if (in_w) begin
                st = RTT_WR;
                c = mode[5:3];
            end else if (mode[2:0] != 3'h0 && pin_d) begin
                st = RTT_NOMINAL;
                c = mode[2:0];
            end else if (mode[8:6] != 3'h0) begin
                st = RTT_PARK;
                c = mode[8:6];
            end else begin
                st = RTT_OFF;
            end
            on = st != RTT_OFF;
            if (quiet > 0) begin
                quiet--;
            end else begin
                check({27'h0, term_o}, {27'h0, st, c});
                check({30'h0, term_o.state}, {30'h0, st});
                check({24'h0, term_ohms_o}, {24'h0, ohm_tab[c]});
                check({31'h0, lanes_o.dq}, {31'h0, on});
                check({31'h0, lanes_o.term_strobe}, {31'h0, on & ~cfg[27] & cfg[28]});
                if (cfg[27])
                    check({26'h0, lanes_o}, {26'h0, on ? 6'h3E : 6'h00});
                if (!self_refresh_i)
                    check({31'h0, odt_rx_en_o}, {31'h0, mode[2:0] != 3'h0});
            end
        end
    end

    //------------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------------
    initial begin
        void'($urandom(78304));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, 8'h00, 4'hF, 0);
        check(rd, 32'h0000_0000);
        wb(0, 8'h04, 4'hF, 0);
        check(rd, 32'h0000_0009);
        wb(0, 8'h08, 4'hF, 0);
        check({29'h0, rd[7:5]}, 32'h0000_0004);
        wb(1, 8'h0C, 4'hF, 32'h0000_01FF);
        wb(0, 8'h0C, 4'hF, 0);
        check(rd, 32'h0000_0000);
        wb(1, 8'h04, 4'h1, 32'h1111_110B);
        wb(0, 8'h04, 4'hF, 0);
        check(rd, 32'h0000_000B);
        wb(1, 8'h04, 4'hF, 32'h0000_0009);
        for (int i = 0; i < 16; i++) begin
            wb(1, 8'h00, 4'hF, {23'h0, 3'(7 - i), 3'h0, 3'(i)});
            pin_req <= i[3];
            repeat (110) @(posedge clk_i);
        end
        for (int i = 0; i < 8; i++) begin
            wb(1, 8'h04, 4'hF, {5'h0, 3'(i), 19'h0, 5'h0A});
            wb(1, 8'h00, 4'hF, {23'h0, 3'h5, 3'(i % 3 + 1), 3'h3});
            pin_req <= i[0];
            repeat (110) @(posedge clk_i);
            cmd(1, 0, i[1]);
            cmd(1, 0, ~i[1]);
            cmd(0, 0, 0);
            repeat (20) @(posedge clk_i);
            cmd(0, 1, 0);
            cmd(1, 0, 0);
            cmd(0, 1, 0);
            cmd(0, 0, 0);
            repeat (30) @(posedge clk_i);
        end
        wb(1, 8'h04, 4'hF, 32'h0000_0009);
        wb(1, 8'h00, 4'hF, 32'h0000_010A);
        pin_req <= 1'b1;
        repeat (110) @(posedge clk_i);
        wb(0, 8'h08, 4'hF, 0);
        check({29'h0, rd[7:5]}, 32'h0000_0007);
        self_refresh_i <= 1'b1;
        quiet = 4;
        cmd(1, 0, 0);
        cmd(0, 0, 0);
        repeat (30) @(posedge clk_i);
        self_refresh_i <= 1'b0;
        zq_cal_i <= 1'b1;
        quiet = 4;
        cmd(1, 0, 0);
        cmd(0, 0, 0);
        repeat (30) @(posedge clk_i);
        zq_cal_i <= 1'b0;
        dll_locked_i <= 1'b0;
        quiet = 100;
        repeat (110) @(posedge clk_i);
        pin_req <= 1'b0;
        repeat (40) @(posedge clk_i);
        pin_req <= 1'b1;
        wb(0, 8'h08, 4'hF, 0);
        check({29'h0, rd[7:5]}, 32'h0000_0003);
        dll_locked_i <= 1'b1;
        quiet = 100;
        for (int i = 0; i < 3000; i++) begin
            if (i % 300 == 0) begin
                cmd(0, 0, 0);
                wb(1, 8'h00, 4'hF, $urandom & 32'h0000_01FF);
                wb(1, 8'h04, 4'hF, ($urandom & 32'h1F07_0307) | 32'h0000_0009);
            end
            pin_req <= ($urandom % 8 == 0) ? ~pin_req : pin_req;
            cmd($urandom % 12 == 0, $urandom % 29 == 0, 1'($urandom));
        end
        cmd(0, 0, 0);
        repeat (20) @(posedge clk_i);
        complete_run();
    end
endmodule
